// ===== hw/pgtm_top.sv
// Power-good tree mask registers and the two masked power-good outputs
//
// Function
// (RQ1) Register a6h: ldo2, switch1, bucks six..one masks
// (RQ2) Output four rail mask: 0 includes, 1 ignores
// (RQ3) Register a7h bits 7..4: control pins 5,4,2,1
// (RQ4) Control pin mask: 0 includes, 1 ignores
// (RQ5) a7h bits 3..0: vtt, shared, switch2, ldo3
// (RQ6) Configuration picks shared source, software cannot
// (RQ7) Register a8h: output two, same layout
// (RQ8) Output two masks independent of output four
// (RQ9) Mask start values come from device configuration
// (RQ10) Output good only while all included sources good
module pgtm_top
   import pgtm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       nrst_i,
   // Register port from the device serial interface engine
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   output logic            reg_rvalid_o,
   // Device configuration: start values and shared source choice
   input  wire logic [7:0] cfg_out4_grp1_dflt_i,
   input  wire logic [7:0] cfg_out4_grp2_dflt_i,
   input  wire logic [7:0] cfg_out2_grp1_dflt_i,
   input  wire logic       cfg_shared_is_ldo_i,
   // Regulator power-good inputs, asynchronous
   input  wire logic [5:0] buck_pg_i,
   input  wire logic       adj_ldo_one_pg_i,
   input  wire logic       adj_ldo_two_pg_i,
   input  wire logic       adj_ldo_three_pg_i,
   input  wire logic       load_switch_one_pg_i,
   input  wire logic       load_switch_two_pg_i,
   input  wire logic       load_switch_three_pg_i,
   input  wire logic       termination_ldo_pg_i,
   // Control input pins, asynchronous
   input  wire logic       control_pin_one_i,
   input  wire logic       control_pin_two_i,
   input  wire logic       control_pin_four_i,
   input  wire logic       control_pin_five_i,
   // Power-good outputs
   output logic            gp_output_four_o,
   output logic            gp_output_two_o
);

   // Mask registers
   logic [7:0] out4_rail_group1_mask_reg;     // Output four, rails group one
   logic [7:0] out4_ctl_rail_group2_mask_reg; // Output four, pins and group two
   logic [7:0] out2_rail_group1_mask_reg;     // Output two, rails group one

   // Configuration load tracking
   logic       cfg_loaded_reg;    // High once defaults are loaded
   logic       shared_is_ldo_reg; // Latched shared source choice

   // Synchroniser stages
   logic [PGTM_SYNC_N-1:0] raw_in;     // Gathered asynchronous inputs
   logic [PGTM_SYNC_N-1:0] sync1_reg;  // First stage, read only by second
   logic [PGTM_SYNC_N-1:0] sync2_reg;  // Second stage, safe to use

   // Synchronised sources by name
   logic [5:0] buck_pg_s;
   logic       ldo1_pg_s;
   logic       ldo2_pg_s;
   logic       ldo3_pg_s;
   logic       sw1_pg_s;
   logic       sw2_pg_s;
   logic       sw3_pg_s;
   logic       vtt_pg_s;
   logic       ctl1_s;
   logic       ctl2_s;
   logic       ctl4_s;
   logic       ctl5_s;
   logic       shared_pg_s; // Shared source after configuration choice

   // Tree source vectors, positions match mask register bits
   logic [7:0]                 rail_group1_good; // Common to both outputs
   logic [7:0]                 group2_good;      // Pins and group two
   logic [PGTM_OUT4_SRC_N-1:0] out4_good;
   logic [PGTM_OUT4_SRC_N-1:0] out4_mask;

   // Decoded write strobes
   logic wr_out4_grp1;
   logic wr_out4_grp2;
   logic wr_out2_grp1;

   // Read data mux
   logic [7:0] rdata_next;

   // Gather all asynchronous inputs into one vector
   always_comb begin
      raw_in = {control_pin_five_i, control_pin_four_i, control_pin_two_i,
                control_pin_one_i, termination_ldo_pg_i, load_switch_three_pg_i,
                load_switch_two_pg_i, load_switch_one_pg_i, adj_ldo_three_pg_i,
                adj_ldo_two_pg_i, adj_ldo_one_pg_i, buck_pg_i};
   end

   // Two-flop synchroniser for pins and power-good signals
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Split the synchronised vector back into named sources
   always_comb begin
      {ctl5_s, ctl4_s, ctl2_s, ctl1_s, vtt_pg_s, sw3_pg_s, sw2_pg_s,
       sw1_pg_s, ldo3_pg_s, ldo2_pg_s, ldo1_pg_s, buck_pg_s} = sync2_reg;
   end

   // Shared source: configuration decides, no register bit touches it
   always_comb begin
      shared_pg_s = shared_is_ldo_reg ? ldo1_pg_s : sw3_pg_s; // RQ6
   end

   // Build rail group one in register bit order
   always_comb begin
      rail_group1_good = '0;
      rail_group1_good[PGTM_BIT_ADJ_LDO_TWO_MASK]     = ldo2_pg_s; // RQ1
      rail_group1_good[PGTM_BIT_LOAD_SWITCH_ONE_MASK] = sw1_pg_s;  // RQ1
      rail_group1_good[PGTM_BIT_BUCK_RAIL_SIX_MASK:PGTM_BIT_BUCK_RAIL_ONE_MASK]
         = buck_pg_s; // RQ1
   end

   // Build pins and rail group two in register bit order
   always_comb begin
      group2_good = '0;
      group2_good[PGTM_BIT_CONTROL_PIN_FIVE_MASK]  = ctl5_s;      // RQ3
      group2_good[PGTM_BIT_CONTROL_PIN_FOUR_MASK]  = ctl4_s;      // RQ3
      group2_good[PGTM_BIT_CONTROL_PIN_TWO_MASK]   = ctl2_s;      // RQ3
      group2_good[PGTM_BIT_CONTROL_PIN_ONE_MASK]   = ctl1_s;      // RQ3
      group2_good[PGTM_BIT_TERMINATION_LDO_MASK]   = vtt_pg_s;    // RQ5
      group2_good[PGTM_BIT_SHARED_SWITCH_LDO_MASK] = shared_pg_s; // RQ5
      group2_good[PGTM_BIT_LOAD_SWITCH_TWO_MASK]   = sw2_pg_s;    // RQ5
      group2_good[PGTM_BIT_ADJ_LDO_THREE_MASK]     = ldo3_pg_s;   // RQ5
   end

   // Output four tree spans both of its registers
   always_comb begin
      out4_good = {group2_good, rail_group1_good};
      out4_mask = {out4_ctl_rail_group2_mask_reg, out4_rail_group1_mask_reg};
   end

   // Address decode of writes, only after defaults are in place
   always_comb begin
      wr_out4_grp1 = reg_wr_i && cfg_loaded_reg
                     && (reg_addr_i == PGTM_OFS_OUT4_RAIL_GROUP1_MASK);
      wr_out4_grp2 = reg_wr_i && cfg_loaded_reg
                     && (reg_addr_i == PGTM_OFS_OUT4_CTL_RAIL_GROUP2_MASK);
      wr_out2_grp1 = reg_wr_i && cfg_loaded_reg
                     && (reg_addr_i == PGTM_OFS_OUT2_RAIL_GROUP1_MASK);
   end

   // Load configuration once, on the first edge after reset release
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_loaded_reg    <= 1'b0;
         shared_is_ldo_reg <= 1'b0;
      end else if (!cfg_loaded_reg) begin
         cfg_loaded_reg    <= 1'b1;
         shared_is_ldo_reg <= cfg_shared_is_ldo_i; // RQ6
      end
   end

   // Output four rail group one mask register
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out4_rail_group1_mask_reg <= PGTM_CLEAR_VAL;
      end else if (!cfg_loaded_reg) begin
         out4_rail_group1_mask_reg <= cfg_out4_grp1_dflt_i; // RQ9
      end else if (wr_out4_grp1) begin
         out4_rail_group1_mask_reg <= reg_wdata_i; // RQ1
      end
   end

   // Output four control pin and rail group two mask register
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out4_ctl_rail_group2_mask_reg <= PGTM_CLEAR_VAL;
      end else if (!cfg_loaded_reg) begin
         out4_ctl_rail_group2_mask_reg <= cfg_out4_grp2_dflt_i; // RQ9
      end else if (wr_out4_grp2) begin
         out4_ctl_rail_group2_mask_reg <= reg_wdata_i; // RQ3
      end
   end

   // Output two rail group one mask register, independent of output four
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out2_rail_group1_mask_reg <= PGTM_CLEAR_VAL;
      end else if (!cfg_loaded_reg) begin
         out2_rail_group1_mask_reg <= cfg_out2_grp1_dflt_i; // RQ9
      end else if (wr_out2_grp1) begin
         out2_rail_group1_mask_reg <= reg_wdata_i; // RQ7
      end
   end

   // Read mux, unmapped offsets read zero
   always_comb begin
      case (reg_addr_i)
         PGTM_OFS_OUT4_RAIL_GROUP1_MASK:     rdata_next = out4_rail_group1_mask_reg;
         PGTM_OFS_OUT4_CTL_RAIL_GROUP2_MASK: rdata_next = out4_ctl_rail_group2_mask_reg;
         PGTM_OFS_OUT2_RAIL_GROUP1_MASK:     rdata_next = out2_rail_group1_mask_reg;
         default:                            rdata_next = PGTM_UNMAPPED_VAL;
      endcase
   end

   // Registered read answer, one cycle after the request
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o  <= PGTM_UNMAPPED_VAL;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
         end
      end
   end

   // Output four tree: mask 0 includes source, mask 1 ignores it
   pgtm_tree #(
      .SRC_N (PGTM_OUT4_SRC_N)
   ) u_tree_out4 (
      .clk_sys_i   (clk_sys_i),
      .nrst_i      (nrst_i),
      .src_good_i  (out4_good),
      .src_mask_i  (out4_mask),      // RQ2 RQ4 RQ10
      .tree_good_o (gp_output_four_o)
   );

   // Output two tree, its own mask register only
   pgtm_tree #(
      .SRC_N (PGTM_OUT2_SRC_N)
   ) u_tree_out2 (
      .clk_sys_i   (clk_sys_i),
      .nrst_i      (nrst_i),
      .src_good_i  (rail_group1_good),
      .src_mask_i  (out2_rail_group1_mask_reg), // RQ8 RQ10
      .tree_good_o (gp_output_two_o)
   );

endmodule

// ===== hw/pgtm_pkg.sv
// Package with offsets, field positions and constants of the power-good mask bank
package pgtm_pkg;

   // Register byte offsets on the device register port
   localparam logic [7:0] PGTM_OFS_OUT4_RAIL_GROUP1_MASK     = 8'ha6;
   localparam logic [7:0] PGTM_OFS_OUT4_CTL_RAIL_GROUP2_MASK = 8'ha7;
   localparam logic [7:0] PGTM_OFS_OUT2_RAIL_GROUP1_MASK     = 8'ha8;

   // Register width and the value read at an unmapped offset
   localparam int         PGTM_REG_W        = 8;
   localparam logic [7:0] PGTM_UNMAPPED_VAL = 8'h00;

   // Value taken by the async reset before configuration defaults load
   localparam logic [7:0] PGTM_CLEAR_VAL = 8'h00;

   // Rail group one field positions (same layout for both outputs)
   localparam int PGTM_BIT_ADJ_LDO_TWO_MASK     = 7;
   localparam int PGTM_BIT_LOAD_SWITCH_ONE_MASK = 6;
   localparam int PGTM_BIT_BUCK_RAIL_SIX_MASK   = 5;
   localparam int PGTM_BIT_BUCK_RAIL_ONE_MASK   = 0;
   localparam int PGTM_NUM_BUCK                 = 6;

   // Control pin and rail group two field positions
   localparam int PGTM_BIT_CONTROL_PIN_FIVE_MASK  = 7;
   localparam int PGTM_BIT_CONTROL_PIN_FOUR_MASK  = 6;
   localparam int PGTM_BIT_CONTROL_PIN_TWO_MASK   = 5;
   localparam int PGTM_BIT_CONTROL_PIN_ONE_MASK   = 4;
   localparam int PGTM_BIT_TERMINATION_LDO_MASK   = 3;
   localparam int PGTM_BIT_SHARED_SWITCH_LDO_MASK = 2;
   localparam int PGTM_BIT_LOAD_SWITCH_TWO_MASK   = 1;
   localparam int PGTM_BIT_ADJ_LDO_THREE_MASK     = 0;

   // Source counts of the two trees
   localparam int PGTM_OUT4_SRC_N = 16;
   localparam int PGTM_OUT2_SRC_N = 8;

   // Number of external input bits that are synchronised
   localparam int PGTM_SYNC_N = 17;

endpackage

// ===== hw/pgtm_tree.sv
// Masked power-good tree: AND of every included source, registered output
module pgtm_tree #(
   parameter int SRC_N = 8
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             nrst_i,
   // Sources and their masks, mask bit set means ignored
   input  wire logic [SRC_N-1:0] src_good_i,
   input  wire logic [SRC_N-1:0] src_mask_i,
   // Tree result
   output logic                  tree_good_o
);

   logic tree_good_next; // Combinational tree value

   // Masked sources read as good, so they cannot pull the output low
   always_comb begin
      tree_good_next = &(src_good_i | src_mask_i);
   end

   // Output flop, low (not good) during reset
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tree_good_o <= 1'b0;
      end else begin
         tree_good_o <= tree_good_next;
      end
   end

endmodule

// ===== test/pgtm_top_monitor.sv
// Assertions on the mask bank register port and the two power-good outputs
module pgtm_top_monitor (
   // Clock, reset and register port
   input wire logic       clk_sys_i, nrst_i, reg_wr_i, reg_rd_i,
   input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
   input wire logic       reg_rvalid_o,
   // Sources and outputs
   input wire logic [5:0] buck_pg_i,
   input wire logic       adj_ldo_one_pg_i, adj_ldo_two_pg_i, adj_ldo_three_pg_i,
   input wire logic       load_switch_one_pg_i, load_switch_two_pg_i,
   input wire logic       load_switch_three_pg_i, termination_ldo_pg_i,
   input wire logic       control_pin_one_i, control_pin_two_i,
   input wire logic       control_pin_four_i, control_pin_five_i,
   input wire logic       gp_output_four_o, gp_output_two_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Rail and control pin levels gathered
   wire logic [12:0] rails = {buck_pg_i, adj_ldo_one_pg_i, adj_ldo_two_pg_i,
      adj_ldo_three_pg_i, load_switch_one_pg_i, load_switch_two_pg_i,
      load_switch_three_pg_i, termination_ldo_pg_i};
   wire logic [3:0]  ctls = {control_pin_one_i, control_pin_two_i,
      control_pin_four_i, control_pin_five_i};
   wire logic        all_ok = &rails && &ctls;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered");
   a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
      else $error("valid without read");
   a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
   a_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside {8'ha6, 8'ha7, 8'ha8})
      |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_wr_readback: assert property (reg_wr_i && reg_addr_i inside {8'ha6, 8'ha7, 8'ha8} ##1
      reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i)
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("readback differs");
   a_all_good_high: assert property (all_ok [*4] |=> gp_output_four_o && gp_output_two_o)
      else $error("output low with all good");
   a_four_steady: assert property (($stable(rails) && $stable(ctls) && !reg_wr_i) [*4]
      |=> $stable(gp_output_four_o))
      else $error("output four moved without cause");
   a_two_ctl_blind: assert property (($stable(rails) && !(reg_wr_i && reg_addr_i != 8'ha7))
      [*4] |=> $stable(gp_output_two_o))
      else $error("output two moved without cause");
   // Main scenarios reached
   cover property (reg_rd_i ##1 reg_rvalid_o);
   cover property ($fell(gp_output_four_o));
   cover property (gp_output_four_o && !gp_output_two_o);
endmodule

bind pgtm_top pgtm_top_monitor i_mon (.*);

// ===== test/pgtm_host.sv
// Host side model: one register port cycle per call
module pgtm_host (
   // Clock
   input  wire logic       clk_sys_i,
   // Register port towards the bank
   output logic            reg_wr_o, reg_rd_o,
   output logic      [7:0] reg_addr_o, reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       reg_rvalid_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle port at time zero
   initial begin
      {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
   end
   // Request held over one edge; registered answer taken just after it
   task automatic xfer(input logic w, r, input logic [7:0] a, d,
                       output logic [7:0] q, output logic v);
      reg_wr_o = w;
      reg_rd_o = r;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(posedge clk_sys_i);
      #1;
      q = reg_rdata_i;
      v = reg_rvalid_i;
   endtask
endmodule

// ===== test/power_good_tree_mask_bench.sv
// Self-checking bench of the power-good mask bank
module power_good_tree_mask_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_sys_i = 0, nrst_i = 0, wr, rd, rvalid, v, sw3 = 1, shl = 1;
   logic [7:0] addr, wdata, rdata, q, m1, m2, m3;  // Model masks a6h a7h a8h
   logic [7:0] g1 = 8'hff, g2 = 8'hff;  // Source levels in register layout
   // Group two as the tree sees it, shared source picked by configuration
   wire  [7:0] g2x = {g2[7:3], (shl ? g2[2] : sw3), g2[1:0]};
   logic       o4, o2;
   int         num_errors = 0, n_compared = 0, cyc = 0;
   localparam logic [7:0] D1 = 8'h5a, D2 = 8'h3c, D3 = 8'ha5;
   // Clock and hang guard
   initial forever #10 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         results();
      end
   end
   pgtm_host i_host (.clk_sys_i(clk_sys_i), .reg_wr_o(wr), .reg_rd_o(rd),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
   pgtm_top i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .cfg_out4_grp1_dflt_i(D1), .cfg_out4_grp2_dflt_i(D2), .cfg_out2_grp1_dflt_i(D3),
      .cfg_shared_is_ldo_i(shl), .buck_pg_i(g1[5:0]), .adj_ldo_one_pg_i(g2[2]),
      .adj_ldo_two_pg_i(g1[7]), .adj_ldo_three_pg_i(g2[0]), .load_switch_one_pg_i(g1[6]),
      .load_switch_two_pg_i(g2[1]), .load_switch_three_pg_i(sw3),
      .termination_ldo_pg_i(g2[3]), .control_pin_one_i(g2[4]), .control_pin_two_i(g2[5]),
      .control_pin_four_i(g2[6]), .control_pin_five_i(g2[7]),
      .gp_output_four_o(o4), .gp_output_two_o(o2));
   // Compare and count
   task automatic chk(input string n, input logic [7:0] e, s);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // Write through the port and track it in the model
   task automatic put(input logic [7:0] a, d);
      i_host.xfer(1, 0, a, d, q, v);
      if (a == 8'ha6) m1 = d;
      if (a == 8'ha7) m2 = d;
      if (a == 8'ha8) m3 = d;
   endtask
   // Read and compare value and valid
   task automatic get(input logic [7:0] a, e);
      i_host.xfer(0, 1, a, 8'h00, q, v);
      chk("rvalid", 8'h01, {7'h0, v});
      chk($sformatf("reg %h", a), e, q);
   endtask
   // Idle until the sync delay passes, then compare both outputs
   task automatic settle();
      repeat (6) i_host.xfer(0, 0, 8'h00, 8'h00, q, v);
      chk("out four", {7'h0, &(g1 | m1) & &(g2x | m2)}, {7'h0, o4});
      chk("out two", {7'h0, &(g1 | m3)}, {7'h0, o2});
   endtask
   // Verdict and end of run
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_i);
      #1 nrst_i = 1;
      m1 = D1;
      m2 = D2;
      m3 = D3;
      settle();
      get(8'ha6, D1);
      get(8'ha7, D2);
      get(8'ha8, D3);
      get(8'ha9, 8'h00);
      $display("test config start values done");
      for (int a = 8'ha6; a <= 8'ha8; a++) begin
         put(a[7:0], 8'h96 ^ a[7:0]);
         get(a[7:0], 8'h96 ^ a[7:0]);
      end
      put(8'ha9, 8'hff);
      get(8'ha6, 8'h96 ^ 8'ha6);
      get(8'ha5, 8'h00);
      $display("test register access done");
      for (int i = 0; i < 16; i++) begin
         put(8'ha6, 8'h00);
         put(8'ha7, 8'h00);
         put(8'ha8, 8'h00);
         {g2, g1} = ~(16'h1 << i);
         settle();
         put(i < 8 ? 8'ha6 : 8'ha7, 8'h01 << (i % 8));
         settle();
         if (i < 8) put(8'ha8, 8'h01 << i);
         settle();
      end
      {g2, g1} = 16'hffff;
      sw3 = 0;
      settle();
      g2[2] = 1'b0;
      put(8'ha7, 8'h04);
      settle();
      $display("test tree masking done");
      // Second reset with the other shared source choice
      nrst_i = 0;
      shl = 1'b0;
      sw3 = 1'b1;
      {g2, g1} = 16'hffff;
      repeat (2) i_host.xfer(0, 0, 8'h00, 8'h00, q, v);
      nrst_i = 1;
      m1 = D1;
      m2 = D2;
      m3 = D3;
      settle();
      get(8'ha6, D1);
      get(8'ha7, D2);
      get(8'ha8, D3);
      sw3 = 1'b0;
      put(8'ha7, 8'h00);
      settle();
      {sw3, g2[2]} = 2'b10;
      settle();
      $display("test reset reload done");
      results();
   end
endmodule
